// file: hdl/cvw_bank.sv
// Indirect configuration-variable write helper bank
`timescale 1ns/1ps
`default_nettype none
`include "cvw_defs.svh"

module cvw_bank (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               CE,
  // Variable access from the command decoder
  input  wire cvw_pkg::cv_req_s   CV_REQ,
  // Read answer
  output logic              [7:0] RD_DATA,
  output logic                    RD_VALID,
  output logic                    RD_HIT,
  // Write to the variable store
  output cvw_pkg::cv_write_s      TGT,
  output logic                    TGT_WR,
  // Status pulses
  output logic                    XFER_DROP,
  output logic                    WR_REFUSED
);

  localparam logic [7:0] LIMITS [`CVW_HELPERS] =
    '{`CVW_LIM_DIGIT, `CVW_LIM_UT, `CVW_LIM_DIGIT};

  // Decode of the request
  logic                   take_wr;
  logic                   take_rd;
  logic [`CVW_HELPERS-1:0] hit;
  logic                   hit_val;
  logic                   helper_any;
  logic                   clr;

  // Helper bank state
  logic [7:0]             hq [`CVW_HELPERS];
  logic [`CVW_HELPERS-1:0] written;
  logic [`CVW_HELPERS-1:0] refused;

  // Assembled transfer
  cvw_pkg::cv_num_t       asm_num;
  cvw_pkg::cv_val_t       asm_val;
  logic                   asm_ok;
  logic                   split;

  // Output registers
  cvw_pkg::cv_write_s     tgt_q;
  cvw_pkg::cv_write_s     tgt_d;
  logic                   tgt_wr_q;
  logic                   tgt_wr_d;
  logic                   drop_q;
  logic                   drop_d;
  logic                   refuse_q;
  logic                   refuse_d;
  logic [7:0]             rd_data_q;
  logic [7:0]             rd_data_d;
  logic                   rd_valid_q;
  logic                   rd_valid_d;
  logic                   rd_hit_q;
  logic                   rd_hit_d;

  assign take_wr = CV_REQ.wr;
  assign take_rd = CV_REQ.rd;
  assign hit_val = (CV_REQ.num == `CVW_VAL_LOW);
  assign helper_any = (|hit) || hit_val;
  // Any write of the last value helper ends the sequence
  assign clr = take_wr && hit_val;
  assign split = written[`CVW_IDX_VAL_HUND];

  genvar g;
  generate
    for (g = 0; g < `CVW_HELPERS; g++)
    begin : g_helper
      assign hit[g] = (CV_REQ.num == `CVW_NUM_HUND + 10'(g));
      cvw_helper_reg #(
        .LIMIT   (LIMITS[g])
      ) u_reg (
        .clk     (CLK),
        .rst     (RST),
        .ce      (CE),
        .wr      (take_wr && hit[g]),
        .clr     (clr),
        .din     (CV_REQ.data),
        .q       (hq[g]),
        .written (written[g]),
        .refused (refused[g])
      );
    end
  endgenerate

  cvw_assemble u_asm (
    .num_hund (hq[`CVW_IDX_NUM_HUND]),
    .num_ut   (hq[`CVW_IDX_NUM_UT]),
    .val_hund (hq[`CVW_IDX_VAL_HUND]),
    .val_low  (CV_REQ.data),
    .split    (split),
    .tgt_num  (asm_num),
    .tgt_val  (asm_val),
    .ok       (asm_ok)
  );

  // Write path: helpers are absorbed, others go straight to the store
  always_comb
  begin
    tgt_d    = tgt_q;
    tgt_wr_d = 1'b0;
    drop_d   = 1'b0;
    refuse_d = take_wr && (|refused);
    if (take_wr && hit_val)
    begin
      // Transfer happens only here, never on the earlier helpers
      if (asm_ok)
      begin
        tgt_d.num  = asm_num;
        tgt_d.data = asm_val;
        tgt_wr_d   = 1'b1;
      end
      else
      begin
        drop_d = 1'b1;
      end
    end
    else if (take_wr && !helper_any)
    begin
      tgt_d.num  = CV_REQ.num;
      tgt_d.data = CV_REQ.data;
      tgt_wr_d   = 1'b1;
    end
  end

  // Read path: helpers answer, others are left to the store
  always_comb
  begin
    rd_valid_d = take_rd;
    rd_hit_d   = take_rd && helper_any;
    rd_data_d  = `CVW_IDLE;
    for (int i = 0; i < `CVW_HELPERS; i++)
    begin
      if (take_rd && hit[i])
      begin
        rd_data_d = hq[i];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tgt_q      <= '0;
      tgt_wr_q   <= 1'b0;
      drop_q     <= 1'b0;
      refuse_q   <= 1'b0;
      rd_data_q  <= `CVW_IDLE;
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
    end
    else if (CE)
    begin
      tgt_q      <= tgt_d;
      tgt_wr_q   <= tgt_wr_d;
      drop_q     <= drop_d;
      refuse_q   <= refuse_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      rd_hit_q   <= rd_hit_d;
    end
  end

  assign TGT        = tgt_q;
  assign TGT_WR     = tgt_wr_q;
  assign XFER_DROP  = drop_q;
  assign WR_REFUSED = refuse_q;
  assign RD_DATA    = rd_data_q;
  assign RD_VALID   = rd_valid_q;
  assign RD_HIT     = rd_hit_q;

  // Checks

  sequence s_val_write;
    CE && take_wr && hit_val;
  endsequence

  sequence s_helper_write;
    CE && take_wr && helper_any && !hit_val;
  endsequence

  property p_num_hund_range;
    @(posedge CLK) disable iff (RST)
      hq[`CVW_IDX_NUM_HUND] <= `CVW_LIM_DIGIT;
  endproperty
  a_num_hund_range: assert property (p_num_hund_range)
    else $error("target hundreds helper out of range");

  property p_num_ut_range;
    @(posedge CLK) disable iff (RST)
      CE && take_wr && hit[`CVW_IDX_NUM_UT]
        && CV_REQ.data > `CVW_LIM_UT
      |=> $stable(hq[`CVW_IDX_NUM_UT]) && WR_REFUSED;
  endproperty
  a_num_ut_range: assert property (p_num_ut_range)
    else $error("units-tens helper took an out-of-range value");

  property p_target_number;
    @(posedge CLK) disable iff (RST)
      s_val_write ##0 asm_ok
      |=> TGT_WR
          && TGT.num == 10'(11'($past(hq[`CVW_IDX_NUM_HUND][3:0]))
                            * `CVW_HUNDRED
                            + 11'($past(hq[`CVW_IDX_NUM_UT])));
  endproperty
  a_target_number: assert property (p_target_number)
    else $error("transfer went to the wrong variable");

  property p_full_value;
    @(posedge CLK) disable iff (RST)
      s_val_write ##0 (!split && asm_ok)
      |=> TGT_WR && TGT.data == $past(CV_REQ.data);
  endproperty
  a_full_value: assert property (p_full_value)
    else $error("three-register value not copied whole");

  property p_copy_on_write;
    @(posedge CLK) disable iff (RST)
      s_val_write ##0 asm_ok |=> TGT_WR ##1 !TGT_WR || $past(CE && take_wr);
  endproperty
  a_copy_on_write: assert property (p_copy_on_write)
    else $error("value helper write did not copy");

  property p_clear_after;
    @(posedge CLK) disable iff (RST)
      s_val_write |=> written == '0 && hq[`CVW_IDX_NUM_HUND] == `CVW_IDLE
        && hq[`CVW_IDX_NUM_UT] == `CVW_IDLE
        && hq[`CVW_IDX_VAL_HUND] == `CVW_IDLE;
  endproperty
  a_clear_after: assert property (p_clear_after)
    else $error("helpers not cleared after transfer");

  // Four-register value: hundreds digit plus the digits written last
  property p_split_value;
    @(posedge CLK) disable iff (RST)
      s_val_write ##0 (split && asm_ok)
      |=> TGT_WR
          && TGT.data == 8'(11'($past(hq[`CVW_IDX_VAL_HUND][3:0]))
                            * `CVW_HUNDRED + 11'($past(CV_REQ.data)));
  endproperty
  a_split_value: assert property (p_split_value)
    else $error("four-register value assembled wrongly");

  // The value hundreds digit never holds more than nine
  property p_val_hund_range;
    @(posedge CLK) disable iff (RST)
      hq[`CVW_IDX_VAL_HUND] <= `CVW_LIM_DIGIT;
  endproperty
  a_val_hund_range: assert property (p_val_hund_range)
    else $error("value hundreds helper out of range");

  // Earlier helpers must never reach the store
  property p_no_early_copy;
    @(posedge CLK) disable iff (RST)
      s_helper_write |=> !TGT_WR;
  endproperty
  a_no_early_copy: assert property (p_no_early_copy)
    else $error("helper write reached the store");

  property p_split_mark;
    @(posedge CLK) disable iff (RST)
      CE && take_wr && hit[`CVW_IDX_VAL_HUND]
        && CV_REQ.data <= `CVW_LIM_DIGIT
      |=> split;
  endproperty
  a_split_mark: assert property (p_split_mark)
    else $error("value hundreds write did not select split value");

  // Dropped transfers still clear, the clear check covers that
  property p_discard;
    @(posedge CLK) disable iff (RST)
      s_val_write ##0 !asm_ok |=> XFER_DROP && !TGT_WR;
  endproperty
  a_discard: assert property (p_discard)
    else $error("bad transfer was not discarded");

  // Reads answer from the helper one cycle later
  property p_read_num_hund;
    @(posedge CLK) disable iff (RST)
      CE && take_rd && hit[`CVW_IDX_NUM_HUND]
      |=> RD_VALID && RD_HIT && RD_DATA == $past(hq[`CVW_IDX_NUM_HUND]);
  endproperty
  a_read_num_hund: assert property (p_read_num_hund)
    else $error("target hundreds readback wrong");

  property p_read_num_ut;
    @(posedge CLK) disable iff (RST)
      CE && take_rd && hit[`CVW_IDX_NUM_UT]
      |=> RD_VALID && RD_HIT && RD_DATA == $past(hq[`CVW_IDX_NUM_UT]);
  endproperty
  a_read_num_ut: assert property (p_read_num_ut)
    else $error("units-tens readback wrong");

endmodule // cvw_bank

`default_nettype wire

// file: hdl/cvw_defs.svh
// Constants for the indirect configuration-variable write helper
// Notes on behaviour
// - Variable 96 holds target hundreds, 0..9
// - Variable 97 holds target units-tens, 0..99
// - Target number built from variables 96 and 97
// - Three-register mode: variable 99 full value
// - Writing 99 copies value to target variable
// - Helpers cleared once the copy is done
// - Four-register mode: 98 hundreds, 99 units-tens
// - Four-register transfer only on write of 99
`ifndef CVW_DEFS_SVH
`define CVW_DEFS_SVH

// Variable numbers of the helpers
`define CVW_NUM_HUND   10'h060
`define CVW_NUM_UT     10'h061
`define CVW_VAL_HUND   10'h062
`define CVW_VAL_LOW    10'h063

// Helper index order inside the helper bank
`define CVW_IDX_NUM_HUND 2'h0
`define CVW_IDX_NUM_UT   2'h1
`define CVW_IDX_VAL_HUND 2'h2
`define CVW_HELPERS      3

// Accepted ranges and idle value
`define CVW_LIM_DIGIT  8'h09
`define CVW_LIM_UT     8'h63
`define CVW_IDLE       8'h00

// Arithmetic and the implemented variable range
`define CVW_HUNDRED    11'h064
`define CVW_VAL_MAX    11'h0ff
`define CVW_CV_FIRST   10'h001
`define CVW_CV_LAST    10'h3ff

`endif

// file: hdl/cvw_pkg.sv
// Types shared by the helper bank files
package cvw_pkg;

  typedef logic [9:0] cv_num_t;
  typedef logic [7:0] cv_val_t;

  typedef struct packed {
    logic    wr;
    logic    rd;
    cv_num_t num;
    cv_val_t data;
  } cv_req_s;

  typedef struct packed {
    cv_num_t num;
    cv_val_t data;
  } cv_write_s;

endpackage

// file: hdl/cvw_helper_reg.sv
// One range-checked helper variable with a written flag
`timescale 1ns/1ps
`default_nettype none
`include "cvw_defs.svh"

module cvw_helper_reg #(
  parameter logic [7:0] LIMIT = `CVW_LIM_DIGIT
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Access
  input  wire logic       wr,
  input  wire logic       clr,
  input  wire logic [7:0] din,
  // State
  output logic      [7:0] q,
  output logic            written,
  output logic            refused
);

  logic [7:0] val_q;
  logic [7:0] val_d;
  logic       wrt_q;
  logic       wrt_d;

  always_comb
  begin
    val_d   = val_q;
    wrt_d   = wrt_q;
    refused = wr && (din > LIMIT);
    // Out-of-range data is dropped so the target stays computable
    if (clr)
    begin
      val_d = `CVW_IDLE;
      wrt_d = 1'b0;
    end
    else if (wr && !refused)
    begin
      val_d = din;
      wrt_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      val_q <= `CVW_IDLE;
      wrt_q <= 1'b0;
    end
    else if (ce)
    begin
      val_q <= val_d;
      wrt_q <= wrt_d;
    end
  end

  assign q       = val_q;
  assign written = wrt_q;

endmodule // cvw_helper_reg

`default_nettype wire

// file: hdl/cvw_assemble.sv
// Builds target number and value from the helper contents
`timescale 1ns/1ps
`default_nettype none
`include "cvw_defs.svh"

module cvw_assemble (
  // Helper contents
  input  wire logic [7:0]  num_hund,
  input  wire logic [7:0]  num_ut,
  input  wire logic [7:0]  val_hund,
  input  wire logic [7:0]  val_low,
  input  wire logic        split,
  // Result
  output cvw_pkg::cv_num_t tgt_num,
  output cvw_pkg::cv_val_t tgt_val,
  output logic             ok
);

  logic [10:0] num_w;
  logic [10:0] val_w;
  logic        num_ok;
  logic        val_ok;

  always_comb
  begin
    num_w = 11'(num_hund[3:0]) * `CVW_HUNDRED + 11'(num_ut);
    // Split value: hundreds times one hundred plus units-tens
    if (split)
    begin
      val_w  = 11'(val_hund[3:0]) * `CVW_HUNDRED + 11'(val_low);
      val_ok = (val_low <= `CVW_LIM_UT) && (val_w <= `CVW_VAL_MAX);
    end
    else
    begin
      val_w  = 11'(val_low);
      val_ok = 1'b1;
    end
    // Helpers themselves are not valid targets
    num_ok = (num_w[9:0] >= `CVW_CV_FIRST) && (num_w[9:0] <= `CVW_CV_LAST)
             && !((num_w[9:0] >= `CVW_NUM_HUND)
                  && (num_w[9:0] <= `CVW_VAL_LOW));
    ok      = num_ok && val_ok;
    tgt_num = num_w[9:0];
    tgt_val = val_w[7:0];
  end

endmodule // cvw_assemble

`default_nettype wire

// file: verif/cvw_station.sv
// Command station model that writes and reads decoder variables
`timescale 1ns/1ps
`default_nettype none

module cvw_station (
  // Clock
  input  wire logic         clk,
  // Request to the bank
  output cvw_pkg::cv_req_s  req,
  // Read answer
  input  wire logic   [7:0] rd_data,
  input  wire logic         rd_valid,
  input  wire logic         rd_hit
);
  int         n_ans;
  logic [7:0] last_rd;
  logic       last_hit;

  initial
  begin
    req = '{1'b0, 1'b0, 10'h3ff, 8'hff};
    n_ans = 0;
  end

  // Answers are taken at the edge where they stand
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      n_ans++;
      last_rd = rd_data;
      last_hit = rd_hit;
    end
  end

  // Released lines show the inverse so stale values never match
  task automatic send(input logic wr, input logic [9:0] num,
                      input logic [7:0] dat);
    @(negedge clk);
    req = '{wr, ~wr, num, dat};
    @(negedge clk);
    req = '{1'b0, 1'b0, ~num, ~dat};
  endtask

  task automatic write_cv(input logic [9:0] num, input logic [7:0] dat);
    send(1'b1, num, dat);
    repeat (3) @(negedge clk);
  endtask

  // Bounded wait for the answer; the bank answers one clock after the request
  task automatic read_cv(input logic [9:0] num);
    int a;
    a = n_ans;
    last_rd = 8'hxx;
    last_hit = 1'bx;
    send(1'b0, num, 8'h00);
    for (int i = 0; i < 8 && n_ans == a; i++)
      @(negedge clk);
  endtask
endmodule // cvw_station

`default_nettype wire

// file: verif/cvw_bank_bench.sv
// Self-checking bench for the indirect variable write helper
`timescale 1ns/1ps
`default_nettype none
`include "cvw_defs.svh"

module cvw_bank_bench;
  logic               clk;
  logic               rst;
  logic               ce;
  cvw_pkg::cv_req_s   req;
  logic         [7:0] rd_data;
  logic               rd_valid;
  logic               rd_hit;
  cvw_pkg::cv_write_s tgt;
  logic               tgt_wr;
  logic               xfer_drop;
  logic               wr_refused;
  cvw_pkg::cv_write_s last_tgt;
  int                 error_cnt;
  int                 n_checks;
  int                 n_xfer;
  int                 n_drop;
  int                 n_ref;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  cvw_bank i_dut (
    .CLK        (clk),
    .RST        (rst),
    .CE         (ce),
    .CV_REQ     (req),
    .RD_DATA    (rd_data),
    .RD_VALID   (rd_valid),
    .RD_HIT     (rd_hit),
    .TGT        (tgt),
    .TGT_WR     (tgt_wr),
    .XFER_DROP  (xfer_drop),
    .WR_REFUSED (wr_refused)
  );

  cvw_station i_host (
    .clk      (clk),
    .req      (req),
    .rd_data  (rd_data),
    .rd_valid (rd_valid),
    .rd_hit   (rd_hit)
  );

  // Pulses are counted so none slips by between checks
  always @(posedge clk)
  begin
    if (tgt_wr === 1'b1)
    begin
      n_xfer++;
      last_tgt = tgt;
    end
    if (xfer_drop === 1'b1)
      n_drop++;
    if (wr_refused === 1'b1)
      n_ref++;
  end

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp,
                         input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %0d want %0d", $time, what,
               got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s count %0d want %0d", $time, what,
               got, exp);
    end
  endtask

  task automatic rd_chk(input logic [9:0] n, input logic [7:0] exp);
    i_host.read_cv(n);
    chk_val({2'h0, i_host.last_rd}, {2'h0, exp}, "readback");
    chk_val({9'h000, i_host.last_hit}, 10'h001, "helper hit");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Number digits first, value last; split adds the value hundreds
  task automatic put(input logic [9:0] n, input logic [8:0] v,
                     input logic split);
    int   x0;
    int   d0;
    logic ok;
    x0 = n_xfer;
    d0 = n_drop;
    ok = (v <= 9'd255) && (n != 10'h000);
    i_host.write_cv(`CVW_NUM_HUND, 8'(n / 10'd100));
    i_host.write_cv(`CVW_NUM_UT, 8'(n % 10'd100));
    if (split)
    begin
      i_host.write_cv(`CVW_VAL_HUND, 8'(v / 9'd100));
      chk_cnt(n_xfer, x0, "early copy");
      i_host.write_cv(`CVW_VAL_LOW, 8'(v % 9'd100));
    end
    else
      i_host.write_cv(`CVW_VAL_LOW, v[7:0]);
    repeat (4) @(negedge clk);
    chk_cnt(n_xfer, x0 + (ok ? 1 : 0), "copies");
    chk_cnt(n_drop, d0 + (ok ? 0 : 1), "discards");
    if (ok)
    begin
      chk_val(last_tgt.num, n, "target number");
      chk_val({2'h0, last_tgt.data}, {1'b0, v}, "target value");
    end
    for (int i = 0; i < 4; i++)
      rd_chk(`CVW_NUM_HUND + 10'(i), 8'h00);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    ce = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    i_host.write_cv(`CVW_NUM_HUND, 8'h07);
    rd_chk(`CVW_NUM_HUND, 8'h07);
    i_host.write_cv(`CVW_NUM_UT, 8'h63);
    rd_chk(`CVW_NUM_UT, 8'h63);
    i_host.write_cv(`CVW_NUM_HUND, 8'h0a);
    rd_chk(`CVW_NUM_HUND, 8'h07);
    i_host.write_cv(`CVW_NUM_UT, 8'h64);
    rd_chk(`CVW_NUM_UT, 8'h63);
    chk_cnt(n_ref, 2, "refusals");
    i_host.read_cv(10'h005);
    chk_val({9'h000, i_host.last_hit}, 10'h000, "unmapped hit");
    i_host.write_cv(10'h005, 8'h2a);
    chk_cnt(n_xfer, 1, "direct writes");
    chk_val(last_tgt.num, 10'h005, "direct number");
    chk_val({2'h0, last_tgt.data}, 10'h02a, "direct value");
    rd_chk(`CVW_NUM_HUND, 8'h07);
    $display("test helper access done");
    put(10'd317, 9'd120, 1'b0);
    put(10'd999, 9'd170, 1'b0);
    $display("test three helpers done");
    put(10'd317, 9'd120, 1'b1);
    put(10'd12, 9'd200, 1'b0);
    put(10'd999, 9'd255, 1'b1);
    put(10'd1, 9'd0, 1'b1);
    $display("test four helpers done");
    put(10'd500, 9'd256, 1'b1);
    put(10'd0, 9'd5, 1'b0);
    chk_cnt(n_ref, 2, "refusals");
    $display("test discards done");
    ce = 1'b0;
    i_host.write_cv(`CVW_NUM_HUND, 8'h05);
    ce = 1'b1;
    rd_chk(`CVW_NUM_HUND, 8'h00);
    i_host.write_cv(`CVW_NUM_HUND, 8'h03);
    rd_chk(`CVW_NUM_HUND, 8'h03);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_chk(`CVW_NUM_HUND, 8'h00);
    $display("test enable and reset done");
    conclude();
  end
endmodule // cvw_bank_bench

`default_nettype wire
